// file: sc_dev.sv
// Functional notes
// - Mode 1,0 starts zero-scale system calibration
// - Mode 1,1 starts full-scale system calibration
// - System step lasts three periods, self six, then mode 0,0
// - Ready goes inactive until new word exists
// - Ready asserts four periods after system command, nine after self
// - Deassert ready within one modulator cycle
// - Host ignores ready one modulator cycle
// - Zero step first, input held stable
// - Full-scale input held stable during step
// - Calibrate at currently selected gain
// - Bipolar zero point is midscale
// - Lone offset or gain rerun, other kept
// - Span 0.8 to 2.1, top below 1.05
// - Reset loads nominal coefficients
// - Host should calibrate after power-up
// - Host waits oscillator start-up first
// - Mode 0,1 selects self-calibration
// - Data read deasserts ready
`default_nettype none
module sc_dev
  import sc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  sc_link_if.dev lnk,
  output logic [15:0] zero_coef,
  output logic [15:0] span_coef,
  output logic [2:0] gain_used,
  output logic busy
);
  typedef enum logic [1:0] {SC_IDLE, SC_CAL, SC_CONV} sc_state_t;

  sc_state_t state_q;
  logic [6:0] mod_cnt_q;
  logic [11:0] per_cnt_q;
  logic [3:0] left_q;
  logic [1:0] mode_q;
  logic [1:0] run_q;
  logic bip_q;
  logic drop_pend_q;
  logic rdy_n_q;
  logic [15:0] data_q;
  logic [15:0] zero_q;
  logic [15:0] span_q;
  logic [2:0] gain_q;
  logic err_q;
  logic mod_tick;
  logic out_tick;
  logic cmd;
  logic [1:0] cmd_mode;
  logic [16:0] raw_span;
  logic [16:0] full_span;
  logic [15:0] conv_word;
  logic [15:0] lvl_off;

  assign cmd_mode = {lnk.cal_mode_hi, lnk.cal_mode_lo};
  assign cmd = lnk.setup_wr && (cmd_mode != MODE_NORMAL);
  assign mod_tick = (mod_cnt_q == MOD_LAST);
  assign out_tick = mod_tick && (per_cnt_q == lnk.rate_div - 12'h001);
  assign lvl_off = lnk.analog_input - zero_q;
  assign conv_word = bip_q ? (lvl_off + MID_CODE) : lvl_off;
  assign raw_span = {1'b0, lnk.analog_input} - {1'b0, zero_q};
  assign full_span = bip_q ? {raw_span[15:0], 1'b0} : raw_span;

  // ---------------------------------------------------------------
  // Modulator and output-rate timebase
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt_q <= '0;
    end else if (cmd || mod_tick) begin
      mod_cnt_q <= '0;
    end else begin
      mod_cnt_q <= mod_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q <= '0;
    end else if (cmd || out_tick) begin
      per_cnt_q <= '0;
    end else if (mod_tick) begin
      per_cnt_q <= per_cnt_q + 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SC_IDLE;
      left_q <= '0;
      run_q <= MODE_NORMAL;
    end else if (cmd) begin
      state_q <= SC_CAL;
      run_q <= cmd_mode;
      left_q <= (cmd_mode == MODE_SELF) ? SELF_STEP_PER
                                        : SYS_STEP_PER;
    end else if (out_tick) begin
      case (state_q)
        SC_CAL: begin
          if (left_q == 4'h1) begin
            state_q <= SC_CONV;
            left_q <= (run_q == MODE_SELF) ? SELF_CONV_PER
                                           : SYS_CONV_PER;
          end else begin
            left_q <= left_q - 4'h1;
          end
        end
        SC_CONV: begin
          if (left_q == 4'h1) begin
            state_q <= SC_IDLE;
            run_q <= MODE_NORMAL;
          end else begin
            left_q <= left_q - 4'h1;
          end
        end
        SC_IDLE: begin
          state_q <= SC_IDLE;
        end
        default: begin
          state_q <= SC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode field readback
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_NORMAL;
    end else if (cmd) begin
      mode_q <= cmd_mode;
    end else if (out_tick && state_q == SC_CAL && left_q == 4'h1) begin
      mode_q <= MODE_NORMAL;
    end
  end

  // ---------------------------------------------------------------
  // Range and gain latched per command
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= GAIN_RST;
      bip_q <= 1'b0;
    end else if (lnk.setup_wr) begin
      gain_q <= lnk.pga_gain;
      bip_q <= lnk.bipolar;
    end
  end

  // ---------------------------------------------------------------
  // Coefficients
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zero_q <= ZERO_COEF_RST;
    end else if (out_tick && state_q == SC_CAL && left_q == 4'h1) begin
      if (run_q == MODE_ZERO) begin
        zero_q <= lnk.analog_input;
      end else if (run_q == MODE_SELF) begin
        zero_q <= ZERO_COEF_RST;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      span_q <= SPAN_COEF_RST;
      err_q <= 1'b0;
    end else if (cmd) begin
      err_q <= 1'b0;
    end else if (out_tick && state_q == SC_CAL && left_q == 4'h1) begin
      if (run_q == MODE_SPAN) begin
        if (full_span < SPAN_MIN || full_span > SPAN_MAX ||
            lnk.analog_input >= PFS_LIM) begin
          err_q <= 1'b1;
        end else begin
          span_q <= raw_span[15:0];
        end
      end else if (run_q == MODE_SELF) begin
        span_q <= SPAN_COEF_RST;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result word and ready flag
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= '0;
    end else if (out_tick && (state_q == SC_IDLE ||
                 (state_q == SC_CONV && left_q == 4'h1))) begin
      data_q <= conv_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drop_pend_q <= 1'b0;
    end else if (cmd) begin
      drop_pend_q <= 1'b1;
    end else if (mod_tick) begin
      drop_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdy_n_q <= 1'b1;
    end else if (out_tick && (state_q == SC_IDLE ||
                 (state_q == SC_CONV && left_q == 4'h1))) begin
      rdy_n_q <= 1'b0;
    end else if (drop_pend_q && mod_tick) begin
      rdy_n_q <= 1'b1;
    end else if (lnk.data_rd) begin
      rdy_n_q <= 1'b1;
    end else if (state_q != SC_IDLE && !drop_pend_q) begin
      rdy_n_q <= 1'b1;
    end
  end

  assign lnk.result_valid_n = rdy_n_q;
  assign lnk.mode_rb_hi = mode_q[1];
  assign lnk.mode_rb_lo = mode_q[0];
  assign lnk.result_data = data_q;
  assign lnk.span_err = err_q;
  assign zero_coef = zero_q;
  assign span_coef = span_q;
  assign gain_used = gain_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= cmd || (state_q != SC_IDLE &&
              !(out_tick && state_q == SC_CONV && left_q == 4'h1));
    end
  end
endmodule : sc_dev
`default_nettype wire

// file: sc_pkg.sv
`default_nettype none
package sc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int MOD_DIV = 128;
  localparam int OSC_START_US = 16000;
  localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
  localparam logic [6:0] MOD_LAST = 7'(MOD_DIV - 1);
  localparam logic [7:0] IGN_CYC = 8'(MOD_DIV);
  localparam logic [3:0] SYS_STEP_PER = 4'h3;
  localparam logic [3:0] SELF_STEP_PER = 4'h6;
  localparam logic [3:0] SYS_CONV_PER = 4'h1;
  localparam logic [3:0] SELF_CONV_PER = 4'h3;
  localparam logic [11:0] RATE_RST = 12'h080;

  // ---------------------------------------------------------------
  // Calibration mode codes {hi, lo}
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SELF = 2'h1;
  localparam logic [1:0] MODE_ZERO = 2'h2;
  localparam logic [1:0] MODE_SPAN = 2'h3;

  // ---------------------------------------------------------------
  // Coefficient defaults and span limits, in input codes
  // ---------------------------------------------------------------
  localparam logic [15:0] ZERO_COEF_RST = 16'h0000;
  localparam logic [15:0] SPAN_COEF_RST = 16'h4000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [16:0] SPAN_MIN = 17'h03333;
  localparam logic [16:0] SPAN_MAX = 17'h08666;
  localparam logic [15:0] PFS_LIM = 16'h4333;
  localparam logic [2:0] GAIN_RST = 3'h0;

  // ---------------------------------------------------------------
  // Controller register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_LEVEL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam int CTL_ZERO = 0;
  localparam int CTL_SPAN = 1;
  localparam int CTL_SELF = 2;
  localparam int CTL_GAIN_LO = 3;
  localparam int CTL_BIPOLAR = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_MODE_HI = 1;
  localparam int ST_MODE_LO = 2;
  localparam int ST_READY = 3;
  localparam int ST_ZERO_DONE = 4;
  localparam int ST_SPAN_ERR = 5;
  localparam int ST_REFUSED = 6;
  localparam int ST_CLK_OK = 7;
  localparam int ST_CAL_NEEDED = 8;
endpackage : sc_pkg
`default_nettype wire

// file: sc_link_if.sv
`default_nettype none
interface sc_link_if;
  logic setup_wr;
  logic cal_mode_hi;
  logic cal_mode_lo;
  logic [2:0] pga_gain;
  logic bipolar;
  logic [11:0] rate_div;
  logic [15:0] analog_input;
  logic data_rd;
  logic result_valid_n;
  logic mode_rb_hi;
  logic mode_rb_lo;
  logic [15:0] result_data;
  logic span_err;

  modport dev (
    input setup_wr, cal_mode_hi, cal_mode_lo, pga_gain, bipolar,
    input rate_div, analog_input, data_rd,
    output result_valid_n, mode_rb_hi, mode_rb_lo, result_data, span_err
  );
  modport host (
    output setup_wr, cal_mode_hi, cal_mode_lo, pga_gain, bipolar,
    output rate_div, analog_input, data_rd,
    input result_valid_n, mode_rb_hi, mode_rb_lo, result_data, span_err
  );
endinterface : sc_link_if
`default_nettype wire

// file: sc_host.sv
`default_nettype none
module sc_host
  import sc_pkg::*;
#(
  parameter int OSC_WAIT = OSC_START_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sc_link_if.host lnk
);
  logic [31:0] osc_cnt_q;
  logic clk_ok_q;
  logic [7:0] ign_q;
  logic zero_done_q;
  logic refused_q;
  logic need_q;
  logic [2:0] gain_q;
  logic bip_q;
  logic [11:0] rate_q;
  logic [15:0] level_q;
  logic wr_q;
  logic [1:0] mode_q;
  logic rd_q;
  logic acc;
  logic wr_ctrl;
  logic [1:0] want;
  logic busy;
  logic ok;
  logic mapped;

  assign acc = psel && penable && pready;
  assign mapped = paddr == REG_CTRL || paddr == REG_RATE ||
                  paddr == REG_LEVEL || paddr == REG_STATUS ||
                  paddr == REG_DATA;
  assign wr_ctrl = acc && pwrite && paddr == REG_CTRL;
  assign busy = (ign_q != 8'h00) || lnk.mode_rb_hi || lnk.mode_rb_lo;
  assign want = pwdata[CTL_SPAN] ? MODE_SPAN :
                pwdata[CTL_ZERO] ? MODE_ZERO :
                pwdata[CTL_SELF] ? MODE_SELF : MODE_NORMAL;
  assign ok = clk_ok_q && !busy && want != MODE_NORMAL &&
              (want != MODE_SPAN || zero_done_q);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        case (paddr)
          REG_RATE: prdata <= {20'h00000, rate_q};
          REG_LEVEL: prdata <= {16'h0000, level_q};
          REG_DATA: prdata <= {16'h0000, lnk.result_data};
          REG_STATUS: begin
            prdata <= '0;
            prdata[ST_BUSY] <= busy;
            prdata[ST_MODE_HI] <= lnk.mode_rb_hi;
            prdata[ST_MODE_LO] <= lnk.mode_rb_lo;
            prdata[ST_READY] <= !lnk.result_valid_n && ign_q == 8'h00;
            prdata[ST_ZERO_DONE] <= zero_done_q;
            prdata[ST_SPAN_ERR] <= lnk.span_err;
            prdata[ST_REFUSED] <= refused_q;
            prdata[ST_CLK_OK] <= clk_ok_q;
            prdata[ST_CAL_NEEDED] <= need_q;
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Oscillator start-up wait
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= '0;
      clk_ok_q <= 1'b0;
    end else if (!clk_ok_q) begin
      osc_cnt_q <= osc_cnt_q + 32'h00000001;
      clk_ok_q <= osc_cnt_q >= 32'(OSC_WAIT - 1);
    end
  end

  // ---------------------------------------------------------------
  // Setup and level registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= GAIN_RST;
      bip_q <= 1'b0;
      rate_q <= RATE_RST;
      level_q <= '0;
    end else if (acc && pwrite && !busy) begin
      if (paddr == REG_CTRL) begin
        gain_q <= pwdata[CTL_GAIN_LO +: 3];
        bip_q <= pwdata[CTL_BIPOLAR];
      end
      if (paddr == REG_RATE && pwdata[11:0] != 12'h000) begin
        rate_q <= pwdata[11:0];
      end
      if (paddr == REG_LEVEL) begin
        level_q <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Command issue and ready masking
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      mode_q <= MODE_NORMAL;
    end else begin
      wr_q <= wr_ctrl && ok;
      if (wr_ctrl && ok) begin
        mode_q <= want;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ign_q <= '0;
    end else if (wr_q) begin
      ign_q <= IGN_CYC;
    end else if (ign_q != 8'h00) begin
      ign_q <= ign_q - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zero_done_q <= 1'b0;
      need_q <= 1'b1;
    end else if (wr_q) begin
      if (mode_q == MODE_ZERO) begin
        zero_done_q <= 1'b1;
      end
      if (mode_q == MODE_SPAN || mode_q == MODE_SELF) begin
        need_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else if (wr_ctrl && !ok) begin
      refused_q <= 1'b1;
    end else if (acc && !pwrite && paddr == REG_STATUS) begin
      refused_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= acc && !pwrite && paddr == REG_DATA;
    end
  end

  assign lnk.setup_wr = wr_q;
  assign lnk.cal_mode_hi = mode_q[1];
  assign lnk.cal_mode_lo = mode_q[0];
  assign lnk.pga_gain = gain_q;
  assign lnk.bipolar = bip_q;
  assign lnk.rate_div = rate_q;
  assign lnk.analog_input = level_q;
  assign lnk.data_rd = rd_q;
endmodule : sc_host
`default_nettype wire

// file: sc_properties.sv
`default_nettype none
module sc_properties
  import sc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic setup_wr,
  input wire logic cal_mode_hi,
  input wire logic cal_mode_lo,
  input wire logic data_rd,
  input wire logic result_valid_n,
  input wire logic mode_rb_hi,
  input wire logic mode_rb_lo,
  input wire logic [11:0] rate_div
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Command tracking
  // ----------------------------------------
  logic [1:0] cmd;
  logic [1:0] mode;
  logic go;
  logic self_q, pend_q, zero_q, rv_q;
  logic [11:0] rate_q;
  logic [23:0] cnt_q, step_n, conv_n;
  assign cmd = {cal_mode_hi, cal_mode_lo};
  assign mode = {mode_rb_hi, mode_rb_lo};
  assign go = setup_wr && (cmd != MODE_NORMAL);
  assign step_n = 24'(rate_q) * (self_q ? 24'h300 : 24'h180);
  assign conv_n = 24'(rate_q) * (self_q ? 24'h480 : 24'h200);

  // Cycles since the last command
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h0;
    end else if (go) begin
      cnt_q <= 24'h1;
    end else if (cnt_q != 24'hFFFFFF) begin
      cnt_q <= cnt_q + 24'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= 12'h0;
      self_q <= 1'b0;
    end else if (go) begin
      rate_q <= rate_div;
      self_q <= (cmd == MODE_SELF);
    end
  end

  // Waiting for the first word after a command
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      rv_q <= 1'b1;
      zero_q <= 1'b0;
    end else begin
      rv_q <= result_valid_n;
      if (go) begin
        pend_q <= 1'b1;
      end else if (rv_q && !result_valid_n) begin
        pend_q <= 1'b0;
      end
      if (go && cmd == MODE_ZERO) begin
        zero_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  mode_set_a: assert property (
    go |=> mode == $past(cmd))
    else $error("mode readback differs from command");
  step_bound_a: assert property (
    mode != MODE_NORMAL |-> cnt_q <= step_n)
    else $error("calibration step runs too long");
  // Mode clears at the command edge plus step_n, seen one edge later
  step_len_a: assert property (
    $past(mode) != MODE_NORMAL && mode == MODE_NORMAL |->
    cnt_q == step_n + 24'h1)
    else $error("calibration step length wrong");
  ready_off_a: assert property (go && !result_valid_n |->
    ##[1:130] result_valid_n)
    else $error("ready not withdrawn after command");
  word_time_a: assert property (
    pend_q && rv_q && !result_valid_n |->
    cnt_q >= conv_n && cnt_q <= conv_n + 24'h1)
    else $error("first word after command at wrong time");
  word_due_a: assert property (pend_q |-> cnt_q <= conv_n + 24'h1)
    else $error("first word after command is late");
  read_clear_a: assert property (data_rd && !result_valid_n |=>
    result_valid_n)
    else $error("data read did not withdraw ready");
  reset_idle_a: assert property ($rose(rst_n) |->
    result_valid_n && mode == MODE_NORMAL)
    else $error("link not idle after reset");
  zero_first_a: assert property (
    setup_wr && cmd == MODE_SPAN |-> zero_q)
    else $error("span step issued before zero step");

  zero_c: cover property (go && cmd == MODE_ZERO);
  span_c: cover property (go && cmd == MODE_SPAN);
  self_c: cover property (go && cmd == MODE_SELF);
  busy_ready_c: cover property (go && !result_valid_n);
endmodule : sc_properties
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench
  import sc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, busy, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] zc, sc;
  logic [2:0] gu;
  int bad_count, comparisons;

  sc_link_if lnk ();
  sc_dev i_sc_dev (.clock(clock), .rst_n(rst_n), .lnk(lnk),
    .zero_coef(zc), .span_coef(sc), .gain_used(gu), .busy(busy));
  sc_host #(.OSC_WAIT(16)) i_sc_host (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  sc_properties i_sc_properties (.clock(clock), .rst_n(rst_n),
    .setup_wr(lnk.setup_wr), .cal_mode_hi(lnk.cal_mode_hi),
    .cal_mode_lo(lnk.cal_mode_lo), .data_rd(lnk.data_rd),
    .result_valid_n(lnk.result_valid_n), .mode_rb_hi(lnk.mode_rb_hi),
    .mode_rb_lo(lnk.mode_rb_lo), .rate_div(lnk.rate_div));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n < 50), 32'h1);
  endtask : apb

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd_reg

  // Step done and fresh word present
  task automatic wait_dev();
    int n;
    n = 0;
    repeat (4) @(posedge clock);
    while (!(busy === 1'b0 && lnk.result_valid_n === 1'b0) && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(32'(n < 3000), 32'h1);
  endtask : wait_dev

  // Issue one calibration, check status while the step runs
  task automatic cal(input logic [31:0] ctl, input logic [15:0] lvl,
                     input logic [1:0] m);
    wr_reg(REG_LEVEL, 32'(lvl));
    wr_reg(REG_CTRL, ctl);
    rd_reg(REG_STATUS);
    check(rd & 32'h0F, {28'h0, 1'b0, m[0], m[1], 1'b1});
    check({30'h0, lnk.mode_rb_hi, lnk.mode_rb_lo}, {30'h0, m});
    wait_dev();
  endtask : cal

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    check({zc, sc}, 32'h00004000);
    check(32'(lnk.result_valid_n), 32'h1);
    rd_reg(8'h14);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    wr_reg(REG_CTRL, 32'h1);
    rd_reg(REG_STATUS);
    check(rd & 32'hC0, 32'h40);
    check(rd & 32'h100, 32'h100);
    repeat (20) @(posedge clock);
    wr_reg(REG_RATE, 32'h1);
    rd_reg(REG_RATE);
    check(rd, 32'h1);
    cal(32'h11, 16'h0100, MODE_ZERO);
    check({zc, 13'h0, gu}, 32'h01000002);
    check(32'(lnk.result_data), 32'h0);
    cal(32'h2, 16'h3500, MODE_SPAN);
    check({zc, sc}, 32'h01003400);
    check(32'(lnk.result_data), 32'h3400);
    rd_reg(REG_DATA);
    check(rd, 32'h3400);
    cal(32'h2, 16'h0200, MODE_SPAN);
    check({zc, sc}, 32'h01003400);
    rd_reg(REG_STATUS);
    check(rd & 32'h20, 32'h20);
    check(rd & 32'h100, 32'h0);
    cal(32'h1, 16'h0300, MODE_ZERO);
    check({zc, sc}, 32'h03003400);
    // Bipolar zero step, with a span order while busy
    wr_reg(REG_CTRL, 32'h41);
    wr_reg(REG_CTRL, 32'h2);
    rd_reg(REG_STATUS);
    check(rd & 32'h47, 32'h43);
    wait_dev();
    check(32'(lnk.result_data), 32'h8000);
    cal(32'h4, 16'h0300, MODE_SELF);
    check({zc, sc}, 32'h00004000);
    // Second reset, then span without zero
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    check({zc, sc}, 32'h00004000);
    rst_n <= 1'b1;
    repeat (20) @(posedge clock);
    wr_reg(REG_CTRL, 32'h2);
    rd_reg(REG_STATUS);
    check(rd & 32'h41, 32'h40);
    print_verdict();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
